/* hdl/urf_pkg.sv */
// Constants for the UART register set and its FIFOs
// Summary of operation
// RULE_01 - Receive storage is 64-byte FIFO
// RULE_02 - FIFO off: receive uses entry zero, overwrites
// RULE_03 - Drop chars when full; keep error bits
// RULE_04 - Transmit storage is 64-byte FIFO
// RULE_05 - FIFO off: transmit byte still stored
// RULE_06 - Address 010: write control, read ident
// RULE_07 - Control bit 0 enables both FIFOs
// RULE_08 - Control bit 1 clears receive FIFO
// RULE_09 - Control bit 2 clears transmit FIFO
// RULE_10 - Control bit 3 selects DMA mode
// RULE_11 - Bits 5:4 set transmit trigger spaces
// RULE_12 - Bits 7:6 set receive trigger level
// RULE_13 - Transmit trigger writable only when enhanced
// RULE_14 - Enhanced-only bits locked unless enhanced
// RULE_15 - Interrupt enable bit mapping
// RULE_16 - Interrupt ident bit layout
// RULE_17 - Divisor latches visible when format bit7
// RULE_18 - Feature and flow chars need 0xBF
// RULE_19 - Threshold registers need enhanced and bit6
// RULE_20 - Ready register needs selects, bit2, no loop
// RULE_21 - Divisor is high:low sixteen bits
package urf_pkg;
  localparam int URF_DEPTH = 64;
  localparam logic [2:0] URF_A_HOLD = 3'h0;
  localparam logic [2:0] URF_A_IEN = 3'h1;
  localparam logic [2:0] URF_A_FCTL = 3'h2;
  localparam logic [2:0] URF_A_LFMT = 3'h3;
  localparam logic [2:0] URF_A_MCTL = 3'h4;
  localparam logic [2:0] URF_A_LCOND = 3'h5;
  localparam logic [2:0] URF_A_MIN = 3'h6;
  localparam logic [2:0] URF_A_SCR = 3'h7;
  localparam logic [7:0] URF_ENH_KEY = 8'h_BF;
  localparam int URF_FC_EN = 0;
  localparam int URF_FC_RXCLR = 1;
  localparam int URF_FC_TXCLR = 2;
  localparam int URF_FC_DMA = 3;
  localparam int URF_EF_ENH = 4;
  localparam int URF_LF_DIVISOR_ACCESS_BIT = 7;
  localparam int URF_MC_RDY = 2;
  localparam int URF_MC_LOOP = 4;
  localparam int URF_MC_TCR = 6;
  localparam logic [7:0] URF_RESET_BYTE = 8'h00;
  localparam logic [7:0] URF_DIV_RESET = 8'h01;
  localparam logic [1:0] URF_IDX_RESET = 2'h0;
  localparam logic [2:0] URF_PRI_NONE = 3'h0;
  localparam logic [2:0] URF_PRI_LINE = 3'h3;
  localparam logic [2:0] URF_PRI_RXDATA = 3'h2;
  localparam logic [2:0] URF_PRI_THRE = 3'h1;
  localparam logic [6:0] URF_TX_TRIG0 = 7'd8;
  localparam logic [6:0] URF_TX_TRIG1 = 7'd16;
  localparam logic [6:0] URF_TX_TRIG2 = 7'd32;
  localparam logic [6:0] URF_TX_TRIG3 = 7'd56;
  localparam logic [6:0] URF_RX_TRIG0 = 7'd8;
  localparam logic [6:0] URF_RX_TRIG1 = 7'd16;
  localparam logic [6:0] URF_RX_TRIG2 = 7'd56;
  typedef enum logic [2:0] {
    URF_BUS_IDLE = 3'b001,
    URF_BUS_ACT = 3'b010,
    URF_BUS_DONE = 3'b100
  } urf_bus_t;
endpackage

/* hdl/urf_fifo.sv */
// Parameter-width FIFO with valid/ready both sides and single-entry mode
`timescale 1ns/1ps
module urf_fifo
  import urf_pkg::*;
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 64
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic single,
  input wire logic overwrite,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("urf_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] cap;
  logic push;
  logic pop;
  logic over;
  assign cap = single ? (AW+1)'(1) : (AW+1)'(DEPTH);
  assign in_ready = count < cap;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign pop = out_valid && out_ready;
  // RULE_02 overwrite entry zero
  assign over = single && overwrite && in_valid && !in_ready && !pop;
  // RULE_03 drop when full
  assign push = in_valid && (in_ready || pop && !single);
  always_ff @(posedge clock) begin
    if (ce && (push || over)) begin
      mem[single ? AW'(0) : wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || (ce && clear)) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      if (single) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (push) wr_ptr <= wr_ptr + AW'(1);
        if (pop) rd_ptr <= rd_ptr + AW'(1);
      end
      if (push && !pop) count <= count + (AW+1)'(1);
      else if (pop && !push) count <= count - (AW+1)'(1);
    end
  end
  a_fifo_bound: assert property (@(posedge clock) // RULE_01
    disable iff (!rst_n) count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_clear: assert property (@(posedge clock) // RULE_08
    disable iff (!rst_n) ce && clear |=> count == '0)
    else $error("fifo clear missed");
endmodule // urf_fifo

/* hdl/urf_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module urf_sync
  import urf_pkg::*;
#(
  parameter logic INIT = 1'b1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) level <= s3;
    end
  end
endmodule // urf_sync

/* hdl/urf_uart.sv */
// UART channel register set with 64-entry transmit and receive FIFOs
`timescale 1ns/1ps
module urf_uart
  import urf_pkg::*;
#(
  parameter int DEPTH = URF_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cs_n,
  input wire logic cs_other_n,
  input wire logic [2:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rdata_oe,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic [2:0] rx_err,
  output logic tx_char_valid,
  output logic [7:0] tx_char,
  input wire logic tx_char_take,
  input wire logic other_rx_ready,
  input wire logic other_tx_ready,
  output logic tx_ready_n,
  output logic rx_ready_n,
  output logic [15:0] divisor,
  output logic [7:0] line_fmt_out,
  output logic [7:0] modem_ctl_out
);
  if (DEPTH != URF_DEPTH) begin : g_bad_depth
    $error("urf_uart trigger levels assume 64 entries");
  end
  localparam int CW = $clog2(DEPTH) + 1;
  logic cs_ok;
  logic wr_q;
  logic rd_q;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] interrupt_enables;
  logic [7:0] fifo_control;
  logic [7:0] line_format;
  logic [7:0] modem_control;
  logic [7:0] scratch;
  logic [7:0] divisor_low;
  logic [7:0] divisor_high;
  logic [7:0] enhanced_features;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] pause_char_one;
  logic [7:0] pause_char_two;
  logic [7:0] flow_threshold_ctrl;
  logic [7:0] fifo_trigger_levels;
  logic overrun;
  logic fifo_on;
  logic enh;
  logic divisor_access_bit;
  logic key;
  logic tcr_ok;
  logic [7:0] next_rdata;
  logic [7:0] interrupt_ident;
  logic [7:0] line_condition;
  logic [7:0] all_ports_ready;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [10:0] rx_out;
  logic [CW-1:0] rx_count;
  logic tx_in_ready;
  logic tx_out_valid;
  logic [CW-1:0] tx_count;
  logic rx_pop;
  logic tx_push;
  logic rx_clr;
  logic tx_clr;
  logic rx_trig;
  logic tx_trig;
  logic cs_sync_n;
  logic rd_sync_n;
  logic wr_sync_n;
  logic cs_other_sync_n;

  // Strobes come from the host's clock domain
  urf_sync u_cs (.clock(clock), .rst_n(rst_n), .ce(ce), .pin(cs_n),
    .level(cs_sync_n));
  urf_sync u_rd (.clock(clock), .rst_n(rst_n), .ce(ce), .pin(rd_n),
    .level(rd_sync_n));
  urf_sync u_wr (.clock(clock), .rst_n(rst_n), .ce(ce), .pin(wr_n),
    .level(wr_sync_n));
  urf_sync u_cso (.clock(clock), .rst_n(rst_n), .ce(ce), .pin(cs_other_n),
    .level(cs_other_sync_n));
  assign cs_ok = !cs_sync_n;
  assign wr_stb = cs_ok && !wr_sync_n && !wr_q;
  assign rd_stb = cs_ok && !rd_sync_n && !rd_q;
  assign fifo_on = fifo_control[URF_FC_EN];
  assign enh = enhanced_features[URF_EF_ENH];
  // RULE_17 divisor latch window
  assign divisor_access_bit = line_format[URF_LF_DIVISOR_ACCESS_BIT];
  // RULE_18 enhanced key value
  assign key = line_format == URF_ENH_KEY;
  // RULE_19 threshold window
  assign tcr_ok = enh && modem_control[URF_MC_TCR];

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = a == r;
  endfunction

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (ce) begin
      wr_q <= cs_ok && !wr_sync_n;
      rd_q <= cs_ok && !rd_sync_n;
    end
  end

  // Write side of register bank
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_enables <= URF_RESET_BYTE;
      fifo_control <= URF_RESET_BYTE;
      line_format <= URF_RESET_BYTE;
      modem_control <= URF_RESET_BYTE;
      scratch <= URF_RESET_BYTE;
      divisor_low <= URF_DIV_RESET;
      divisor_high <= URF_RESET_BYTE;
      enhanced_features <= URF_RESET_BYTE;
      resume_char_one <= URF_RESET_BYTE;
      resume_char_two <= URF_RESET_BYTE;
      pause_char_one <= URF_RESET_BYTE;
      pause_char_two <= URF_RESET_BYTE;
      flow_threshold_ctrl <= URF_RESET_BYTE;
      fifo_trigger_levels <= URF_RESET_BYTE;
    end else if (ce) begin
      // RULE_08 self-clearing receive clear
      fifo_control[URF_FC_RXCLR] <= 1'b0;
      // RULE_09 self-clearing transmit clear
      fifo_control[URF_FC_TXCLR] <= 1'b0;
      if (wr_stb) begin
        if (key && hit(addr, URF_A_FCTL)) begin
          enhanced_features <= wdata;
        end else if (key && hit(addr, URF_A_MCTL)) begin
          resume_char_one <= wdata;
        end else if (key && hit(addr, URF_A_LCOND)) begin
          resume_char_two <= wdata;
        end else if (key && hit(addr, URF_A_MIN)) begin
          pause_char_one <= wdata;
        end else if (key && hit(addr, URF_A_SCR)) begin
          pause_char_two <= wdata;
        end else if (divisor_access_bit && hit(addr, URF_A_HOLD)) begin
          divisor_low <= wdata;
        end else if (divisor_access_bit && hit(addr, URF_A_IEN)) begin
          divisor_high <= wdata;
        end else if (tcr_ok && hit(addr, URF_A_MIN)) begin
          flow_threshold_ctrl <= wdata;
        end else if (tcr_ok && hit(addr, URF_A_SCR)) begin
          fifo_trigger_levels <= wdata;
        end else begin
          case (addr)
            URF_A_IEN: begin
              // RULE_14 upper enables locked
              interrupt_enables <= enh ? wdata :
                {interrupt_enables[7:4], wdata[3:0]};
            end
            URF_A_FCTL: begin
              // RULE_06 control written here
              // RULE_07 enable, RULE_10 DMA mode, RULE_12 rx trigger
              fifo_control[7:6] <= wdata[7:6];
              fifo_control[3:0] <= wdata[3:0];
              // RULE_13 tx trigger gated
              // RULE_11 tx trigger field
              if (enh) fifo_control[5:4] <= wdata[5:4];
            end
            URF_A_LFMT: line_format <= wdata;
            URF_A_MCTL: begin
              // RULE_14 upper modem bits locked
              modem_control <= enh ? wdata :
                {modem_control[7:5], wdata[4:0]};
            end
            URF_A_SCR: scratch <= wdata;
            default: begin
            end
          endcase
        end
      end
    end
  end

  assign rx_clr = fifo_control[URF_FC_RXCLR];
  assign tx_clr = fifo_control[URF_FC_TXCLR];
  assign tx_push = wr_stb && hit(addr, URF_A_HOLD) && !divisor_access_bit && !key;
  assign rx_pop = rd_stb && hit(addr, URF_A_HOLD) && !divisor_access_bit && !key;

  // RULE_01 receive storage
  // RULE_03 error bits ride with each byte
  urf_fifo #(.WIDTH(11), .DEPTH(DEPTH)) u_rx (
    .clock(clock), .rst_n(rst_n), .ce(ce), .clear(rx_clr),
    .single(!fifo_on), .overwrite(1'b1),
    .in_valid(rx_char_valid), .in_ready(rx_in_ready),
    .in_data({rx_err, rx_char}),
    .out_valid(rx_out_valid), .out_ready(rx_pop),
    .out_data(rx_out), .count(rx_count));

  // RULE_04 transmit storage
  // RULE_05 byte kept even with FIFO off
  urf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
    .clock(clock), .rst_n(rst_n), .ce(ce), .clear(tx_clr),
    .single(!fifo_on), .overwrite(1'b0),
    .in_valid(tx_push), .in_ready(tx_in_ready), .in_data(wdata),
    .out_valid(tx_out_valid), .out_ready(tx_char_take),
    .out_data(tx_char), .count(tx_count));

  assign tx_char_valid = tx_out_valid;

  // Overrun sticks until line status is read; set wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (ce) begin
      if (rx_char_valid && !rx_in_ready) overrun <= 1'b1;
      else if (rd_stb && hit(addr, URF_A_LCOND) && !key) overrun <= 1'b0;
    end
  end

  // RULE_12 receive trigger decode
  always_comb begin
    case (fifo_control[7:6])
      2'b00: rx_trig = rx_count >= CW'(URF_RX_TRIG0);
      2'b01: rx_trig = rx_count >= CW'(URF_RX_TRIG1);
      2'b10: rx_trig = rx_count >= CW'(URF_RX_TRIG2);
      default: rx_trig = rx_count >= CW'(URF_RX_TRIG2);
    endcase
  end

  // RULE_11 transmit trigger on free spaces
  always_comb begin
    case (fifo_control[5:4])
      2'b00: tx_trig = CW'(DEPTH) - tx_count >= CW'(URF_TX_TRIG0);
      2'b01: tx_trig = CW'(DEPTH) - tx_count >= CW'(URF_TX_TRIG1);
      2'b10: tx_trig = CW'(DEPTH) - tx_count >= CW'(URF_TX_TRIG2);
      default: tx_trig = CW'(DEPTH) - tx_count >= CW'(URF_TX_TRIG3);
    endcase
  end

  // RULE_16 ident layout
  // RULE_15 enables gate the sources
  always_comb begin
    interrupt_ident = {{2{fifo_on}}, 2'b00, URF_PRI_NONE, 1'b1};
    if (interrupt_enables[2] && (overrun || rx_out[10:8] != 3'h0)
        && rx_out_valid) begin
      interrupt_ident[3:0] = {URF_PRI_LINE, 1'b0};
    end else if (interrupt_enables[0] && rx_out_valid
                 && (rx_trig || !fifo_on)) begin
      interrupt_ident[3:0] = {URF_PRI_RXDATA, 1'b0};
    end else if (interrupt_enables[1] && !tx_out_valid) begin
      interrupt_ident[3:0] = {URF_PRI_THRE, 1'b0};
    end
  end

  assign line_condition = {1'b0, !tx_out_valid, !tx_out_valid,
    rx_out_valid ? rx_out[10:8] : 3'h0, overrun, rx_out_valid};
  assign all_ports_ready = {2'b00, other_rx_ready, !rx_ready_n,
    2'b00, other_tx_ready, !tx_ready_n};

  // Read multiplexer, priority mirrors the write side plus the ready register ahead of the trigger levels
  always_comb begin
    next_rdata = URF_RESET_BYTE;
    if (key && hit(addr, URF_A_FCTL)) begin
      next_rdata = enhanced_features;
    end else if (key && hit(addr, URF_A_MCTL)) begin
      next_rdata = resume_char_one;
    end else if (key && hit(addr, URF_A_LCOND)) begin
      next_rdata = resume_char_two;
    end else if (key && hit(addr, URF_A_MIN)) begin
      next_rdata = pause_char_one;
    end else if (key && hit(addr, URF_A_SCR)) begin
      next_rdata = pause_char_two;
    end else if (divisor_access_bit && hit(addr, URF_A_HOLD)) begin
      next_rdata = divisor_low;
    end else if (divisor_access_bit && hit(addr, URF_A_IEN)) begin
      next_rdata = divisor_high;
    end else if (tcr_ok && hit(addr, URF_A_MIN)) begin
      next_rdata = flow_threshold_ctrl;
    // RULE_20 ready register gating
    end else if (hit(addr, URF_A_SCR) && cs_ok && !cs_other_sync_n
                 && modem_control[URF_MC_RDY]
                 && !modem_control[URF_MC_LOOP]) begin
      next_rdata = all_ports_ready;
    end else if (tcr_ok && hit(addr, URF_A_SCR)) begin
      next_rdata = fifo_trigger_levels;
    end else begin
      case (addr)
        URF_A_HOLD: next_rdata = rx_out[7:0];
        URF_A_IEN: next_rdata = interrupt_enables;
        // RULE_06 ident read here
        URF_A_FCTL: next_rdata = interrupt_ident;
        URF_A_LFMT: next_rdata = line_format;
        URF_A_MCTL: next_rdata = modem_control;
        URF_A_LCOND: next_rdata = line_condition;
        URF_A_MIN: next_rdata = URF_RESET_BYTE;
        URF_A_SCR: next_rdata = scratch;
        default: next_rdata = URF_RESET_BYTE;
      endcase
    end
  end

  // Data bus captured at strobe edge, driven while read held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= URF_RESET_BYTE;
      rdata_oe <= 1'b0;
    end else if (ce) begin
      if (rd_stb) rdata <= next_rdata;
      rdata_oe <= cs_ok && !rd_sync_n;
    end
  end

  // RULE_10 DMA ready styles, active low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_ready_n <= 1'b1;
      tx_ready_n <= 1'b0;
    end else if (ce) begin
      if (fifo_on && fifo_control[URF_FC_DMA]) begin
        rx_ready_n <= !(rx_trig || (rx_out_valid && !rx_trig && 1'b0));
        tx_ready_n <= !tx_trig;
      end else begin
        rx_ready_n <= !rx_out_valid;
        tx_ready_n <= tx_out_valid;
      end
    end
  end

  // RULE_21 sixteen-bit divisor
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      divisor <= {URF_RESET_BYTE, URF_DIV_RESET};
      line_fmt_out <= URF_RESET_BYTE;
      modem_ctl_out <= URF_RESET_BYTE;
    end else if (ce) begin
      divisor <= {divisor_high, divisor_low};
      line_fmt_out <= line_format;
      modem_ctl_out <= modem_control;
    end
  end

  a_txtrig_lock: assert property (@(posedge clock) // RULE_13
    disable iff (!rst_n) ce && wr_stb && !enh |=>
    $stable(fifo_control[5:4])) else $error("tx trigger moved unlocked");
  a_ien_lock: assert property (@(posedge clock) // RULE_14
    disable iff (!rst_n) ce && !enh |=> $stable(interrupt_enables[7:4]))
    else $error("enhanced enables changed while locked");
  a_rxclr_self: assert property (@(posedge clock) // RULE_08
    disable iff (!rst_n) ce && rx_clr |=> !rx_clr && rx_count == '0)
    else $error("receive clear did not self clear");
  a_txclr_self: assert property (@(posedge clock) // RULE_09
    disable iff (!rst_n) ce && tx_clr |=> !tx_clr && tx_count == '0)
    else $error("transmit clear did not self clear");
  a_single_entry: assert property (@(posedge clock) // RULE_02
    disable iff (!rst_n) !fifo_on && rx_count <= CW'(1) |=>
    rx_count <= CW'(1)) else $error("receive held two entries, FIFO off");
  a_ident_mirror: assert property (@(posedge clock) // RULE_16
    disable iff (!rst_n) ce && rd_stb && hit(addr, URF_A_FCTL) && !key |=>
    rdata[7:6] == {2{$past(fifo_on)}}) else $error("ident top bits wrong");
  a_divisor_form: assert property (@(posedge clock) // RULE_21
    disable iff (!rst_n) ce |=> divisor == {$past(divisor_high),
    $past(divisor_low)}) else $error("divisor not formed from latches");
  a_rx_drop_full: assert property (@(posedge clock) // RULE_03
    disable iff (!rst_n) ce && fifo_on && rx_count == CW'(DEPTH) &&
    !rx_pop && !rx_clr |=> $stable(rx_count)) else $error("full count moved");
endmodule // urf_uart

/* testbench/urf_shift_model.sv */
// Shift-register side stand-in: takes transmit bytes, injects receive chars
`timescale 1ns/1ps
module urf_shift_model (
  input wire logic clock,
  input wire logic stall,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char,
  output logic tx_char_take,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic [2:0] rx_err
);
  logic [7:0] got [$];
  initial begin
    tx_char_take = 1'b0;
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_err = 3'h0;
  end
  // Skip a cycle after each take: the registered take pops the FIFO one edge later
  always @(posedge clock) begin
    tx_char_take <= tx_char_valid && !tx_char_take && !stall;
    if (tx_char_valid && !tx_char_take && !stall) begin
      got.push_back(tx_char);
    end
  end
  // Data lines carry junk between pulses
  task automatic send(input logic [7:0] c, input logic [2:0] e);
    @(posedge clock);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    rx_err <= e;
    @(posedge clock);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_err <= ~e;
  endtask
endmodule // urf_shift_model

/* testbench/tb_urf_uart.sv */
// Register-level bench for the UART register set and FIFOs
`timescale 1ns/1ps
module tb_urf_uart;
  import urf_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic stall = 1'b1;
  logic [7:0] rdata;
  logic rdata_oe;
  logic rx_char_valid;
  logic [7:0] rx_char;
  logic [2:0] rx_err;
  logic tx_char_valid;
  logic [7:0] tx_char;
  logic tx_char_take;
  logic tx_ready_n;
  logic rx_ready_n;
  logic [15:0] divisor;
  logic [7:0] line_fmt_out;
  logic [7:0] modem_ctl_out;
  logic cs_other_n = 1'b1;
  logic [1:0] other_rdy = 2'b10;
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  initial begin
    forever #12.5 clock = ~clock;
  end
  urf_uart dut_u (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .cs_n(cs_n),
    .cs_other_n(cs_other_n), .addr(addr), .rd_n(rd_n), .wr_n(wr_n),
    .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_err(rx_err),
    .tx_char_valid(tx_char_valid), .tx_char(tx_char),
    .tx_char_take(tx_char_take), .other_rx_ready(other_rdy[1]),
    .other_tx_ready(other_rdy[0]), .tx_ready_n(tx_ready_n),
    .rx_ready_n(rx_ready_n), .divisor(divisor),
    .line_fmt_out(line_fmt_out), .modem_ctl_out(modem_ctl_out)
  );
  urf_shift_model shift_u (
    .clock(clock), .stall(stall), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_take(tx_char_take),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_err(rx_err)
  );
  task automatic results();
    $display("mismatches %0d checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fail_wait();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask
  // Strobe held past the three-flop filter, then idle long enough
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cs_n <= 1'b0;
    addr <= a;
    wdata <= d;
    wr_n <= 1'b0;
    repeat (6) @(posedge clock);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  task automatic rdm(input logic [2:0] a, input logic [7:0] m,
                     input logic [7:0] exp);
    int k;
    cs_n <= 1'b0;
    addr <= a;
    rd_n <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (rdata_oe !== 1'b1 && k < 20);
    if (k >= 20) fail_wait();
    check(rdata & m, exp);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rdm(a, 8'hFF, exp);
  endtask
  task automatic put_tx(input int cnt);
    for (int i = 0; i < cnt; i++) wr(URF_A_HOLD, 8'(i + 1));
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    wr(URF_A_LFMT, 8'h83);
    rdc(URF_A_HOLD, URF_DIV_RESET);
    wr(URF_A_HOLD, 8'h34);
    wr(URF_A_IEN, 8'h12);
    check(divisor[15:8], 8'h12);
    check(divisor[7:0], 8'h34);
    wr(URF_A_LFMT, 8'h03);
    wr(URF_A_IEN, 8'hFF);
    rdc(URF_A_IEN, 8'h0F);
    wr(URF_A_LFMT, URF_ENH_KEY);
    wr(URF_A_FCTL, 8'h10);
    rdc(URF_A_FCTL, 8'h10);
    wr(URF_A_LFMT, 8'h03);
    wr(URF_A_IEN, 8'hF0);
    rdc(URF_A_IEN, 8'hF0);
    wr(URF_A_FCTL, 8'h39);
    rdm(URF_A_FCTL, 8'hC0, 8'hC0);
    rdm(URF_A_FCTL, 8'h0F, 8'h01);
    put_tx(8);
    check({7'h0, tx_ready_n}, 8'h00);
    wr(URF_A_HOLD, 8'h09);
    check({7'h0, tx_ready_n}, 8'h01);
    wr(URF_A_HOLD, 8'h0A);
    for (int i = 10; i < 65; i++) wr(URF_A_HOLD, 8'(i + 1));
    stall <= 1'b0;
    n = 0;
    while (shift_u.got.size() < 64 && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) fail_wait();
    repeat (8) @(posedge clock);
    check({7'h0, tx_char_valid}, 8'h00);
    check(8'(shift_u.got.size()), 8'd64);
    for (int i = 0; i < 64; i++) check(shift_u.got[i], 8'(i + 1));
    stall <= 1'b1;
    wr(URF_A_LFMT, URF_ENH_KEY);
    wr(URF_A_FCTL, 8'h00);
    wr(URF_A_LFMT, 8'h03);
    wr(URF_A_FCTL, 8'h09);
    put_tx(9);
    check({7'h0, tx_ready_n}, 8'h01);
    wr(URF_A_FCTL, 8'h0D);
    repeat (4) @(posedge clock);
    check({7'h0, tx_char_valid}, 8'h00);
    for (int i = 0; i < 65; i++) begin
      shift_u.send(8'(i), 3'(i + 1));
      repeat (4) @(posedge clock);
      if (i == 6) check({7'h0, rx_ready_n}, 8'h01);
      if (i == 7) check({7'h0, rx_ready_n}, 8'h00);
    end
    rdm(URF_A_LCOND, 8'h1F, 8'h07);
    for (int i = 0; i < 64; i++) rdc(URF_A_HOLD, 8'(i));
    rdm(URF_A_LCOND, 8'h03, 8'h00);
    shift_u.send(8'h41, 3'h0);
    shift_u.send(8'h42, 3'h0);
    wr(URF_A_FCTL, 8'h0B);
    rdm(URF_A_LCOND, 8'h01, 8'h00);
    wr(URF_A_FCTL, 8'h00);
    rdm(URF_A_FCTL, 8'hC0, 8'h00);
    shift_u.send(8'h11, 3'h0);
    shift_u.send(8'h22, 3'h0);
    repeat (4) @(posedge clock);
    check({7'h0, rx_ready_n}, 8'h00);
    rdc(URF_A_HOLD, 8'h22);
    rdm(URF_A_LCOND, 8'h01, 8'h00);
    shift_u.got.delete();
    stall <= 1'b0;
    wr(URF_A_HOLD, 8'h77);
    repeat (10) @(posedge clock);
    check(8'(shift_u.got.size()), 8'd1);
    check(shift_u.got[0], 8'h77);
    // modem lock, threshold and ready windows
    wr(URF_A_MCTL, 8'hE4);
    check(modem_ctl_out, 8'h04);
    wr(URF_A_LFMT, URF_ENH_KEY);
    check(line_fmt_out, URF_ENH_KEY);
    wr(URF_A_FCTL, 8'h10);
    wr(URF_A_LFMT, 8'h03);
    wr(URF_A_MCTL, 8'h44);
    check(modem_ctl_out, 8'h44);
    wr(URF_A_SCR, 8'h5A);
    rdc(URF_A_SCR, 8'h5A);
    cs_other_n <= 1'b0;
    rdc(URF_A_SCR, 8'h21);
    other_rdy <= 2'b01;
    rdc(URF_A_SCR, 8'h03);
    cs_other_n <= 1'b1;
    wr(URF_A_MCTL, 8'h04);
    rdc(URF_A_SCR, 8'h00);
    results();
  end
endmodule // tb_urf_uart
